// ==== core/lpw_top.sv ====
`timescale 1ns/1ns
// ====================================================================
// Idle and sleep sequencer with wake-up and interrupt entry control.
module lpw_top #(
  parameter int P0_W = 8,
  parameter int P1_W = 7
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire lpw_pkg::lpw_axil_req_t s_axil_req,
  output lpw_pkg::lpw_axil_rsp_t s_axil_rsp,
  input wire logic [P0_W-1:0] p0_pin,
  input wire logic [P1_W-1:0] p1_pin,
  input wire logic hosc_tick,
  input wire logic losc_tick,
  input wire logic basic_timer_ovf,
  input wire logic pwm_ovf,
  input wire logic [2:0] cmp_irq,
  input wire logic adc_irq,
  input wire logic cpu_reti,
  output logic cpu_halt,
  output logic sys_clk_en,
  output logic hosc_run,
  output logic losc_run,
  output logic basic_timer_run,
  output logic pwm_run,
  output logic mode_slow,
  output logic vector_req,
  output logic [7:0] vector_addr
);

  lpw_pkg::lpw_state_t state_q;
  logic [P1_W-1:0] p1_wake_en_q;
  logic idle_req_q;
  logic sleep_req_q;
  logic low_clk_q;
  logic stop_hosc_q;
  logic xtal_q;
  logic wake_flag_q;
  logic wake_ien_q;
  logic gie_q;
  logic in_svc_q;
  logic [1:0] int_edge_q;
  logic [lpw_pkg::NUM_IRQ-1:0] int_req_q;
  logic [lpw_pkg::NUM_IRQ-1:0] int_en_q;
  logic [lpw_pkg::NUM_IRQ-1:0] irq_set;
  logic pend_q;
  logic pend_ext_q;
  logic [lpw_pkg::WARM_W-1:0] warm_cnt_q;
  logic [lpw_pkg::WARM_W-1:0] warm_last;
  logic [1:0] div_q;
  logic clk_en_q;
  logic [7:0] vector_addr_q;
  logic wr_en;
  logic [lpw_pkg::ADDR_W-1:0] wr_addr;
  logic [lpw_pkg::DATA_W-1:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_hit;
  logic [lpw_pkg::ADDR_W-1:0] rd_addr;
  logic [lpw_pkg::DATA_W-1:0] rd_data;
  logic rd_hit;
  logic [P0_W-1:0] p0_rise;
  logic [P0_W-1:0] p0_fall;
  logic [P1_W-1:0] p1_rise;
  logic [P1_W-1:0] p1_fall;
  logic osc_wr;
  logic wctl_wr;
  logic int_wr;
  logic pin_wake;
  logic ext_edge;
  logic ext_wake;
  logic going_sleep;
  logic entering;
  logic wake_fire;
  logic wake_ext;
  logic take_svc;
  logic warm_done;
  logic slow_tick;

  // ==================================================================
  // Bus slave and pin detectors.
  lpw_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .req(s_axil_req),
    .rsp(s_axil_rsp),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_hit(wr_hit),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_hit(rd_hit)
  );

  lpw_wake_edge #(.N(P0_W)) u_p0 (.aclk(aclk), .aresetn(aresetn), .pin(p0_pin), .rise(p0_rise), .fall(p0_fall));
  lpw_wake_edge #(.N(P1_W)) u_p1 (.aclk(aclk), .aresetn(aresetn), .pin(p1_pin), .rise(p1_rise), .fall(p1_fall));

  // ==================================================================
  // Wake and interrupt events.
  assign pin_wake = (|(p0_rise | p0_fall)) | (|((p1_rise | p1_fall) & p1_wake_en_q));
  assign ext_edge = lpw_pkg::edge_hit(int_edge_q, p0_rise[0], p0_fall[0]);
  assign ext_wake = ext_edge && int_en_q[lpw_pkg::IRQ_EXT];
  assign irq_set = {adc_irq, pwm_ovf, basic_timer_ovf, cmp_irq, ext_wake};
  assign osc_wr = wr_en && wr_strb[0] && lpw_pkg::reg_hit(wr_addr, lpw_pkg::OFF_OSC_MODE);
  assign wctl_wr = wr_en && lpw_pkg::reg_hit(wr_addr, lpw_pkg::OFF_WAKE_CTL);
  assign int_wr = wr_en && lpw_pkg::reg_hit(wr_addr, lpw_pkg::OFF_INT_REQ);
  assign going_sleep = sleep_req_q || (osc_wr && wr_data[lpw_pkg::OSC_SLEEP_BIT]);
  assign entering = state_q == lpw_pkg::ST_RUN &&
    (going_sleep || idle_req_q || (osc_wr && wr_data[lpw_pkg::OSC_IDLE_BIT]));
  assign wake_fire = (state_q == lpw_pkg::ST_IDLE && (pin_wake || basic_timer_ovf || pend_q)) ||
    (state_q == lpw_pkg::ST_SLEEP && (pin_wake || pend_q));
  assign wake_ext = pend_q ? pend_ext_q : ext_wake;
  assign take_svc = state_q == lpw_pkg::ST_RUN && gie_q && !in_svc_q &&
    ((|(int_req_q & int_en_q)) || (wake_flag_q && wake_ien_q));
  assign warm_last = (xtal_q ? lpw_pkg::WARM_XTAL_CLKS : lpw_pkg::WARM_RC_CLKS) - 12'h001;
  assign warm_done = state_q == lpw_pkg::ST_WARM && hosc_tick && warm_cnt_q == warm_last;
  assign slow_tick = losc_tick && div_q == lpw_pkg::SLOW_DIV_LAST;

  // ==================================================================
  // Mode sequencer.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= lpw_pkg::ST_RUN;
    end else begin
      case (state_q)
        lpw_pkg::ST_RUN: begin
          if (sleep_req_q) begin
            state_q <= lpw_pkg::ST_SLEEP;
          end else if (idle_req_q) begin
            state_q <= lpw_pkg::ST_IDLE;
          end
        end
        lpw_pkg::ST_IDLE: begin
          if (wake_fire) begin
            state_q <= lpw_pkg::ST_RUN;
          end
        end
        lpw_pkg::ST_SLEEP: begin
          if (wake_fire) begin
            state_q <= lpw_pkg::ST_WARM;
          end
        end
        lpw_pkg::ST_WARM: begin
          if (warm_done) begin
            state_q <= lpw_pkg::ST_RUN;
          end
        end
        default: begin
          state_q <= lpw_pkg::ST_RUN;
        end
      endcase
    end
  end

  // Pending wake that coincides with a mode request.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_q <= 1'b0;
      pend_ext_q <= 1'b0;
    end else if (wake_fire) begin
      pend_q <= 1'b0;
      pend_ext_q <= 1'b0;
    end else if (entering && (pin_wake || (basic_timer_ovf && !going_sleep))) begin
      pend_q <= 1'b1;
      pend_ext_q <= ext_wake;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || state_q != lpw_pkg::ST_WARM) begin
      warm_cnt_q <= '0;
    end else if (hosc_tick) begin
      warm_cnt_q <= warm_cnt_q + 12'h001;
    end
  end

  // ==================================================================
  // Oscillator mode register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idle_req_q <= lpw_pkg::OSC_BIT_RST;
      sleep_req_q <= lpw_pkg::OSC_BIT_RST;
      low_clk_q <= lpw_pkg::OSC_BIT_RST;
      stop_hosc_q <= lpw_pkg::OSC_BIT_RST;
      xtal_q <= lpw_pkg::OSC_BIT_RST;
    end else begin
      if (osc_wr) begin
        idle_req_q <= wr_data[lpw_pkg::OSC_IDLE_BIT];
        sleep_req_q <= wr_data[lpw_pkg::OSC_SLEEP_BIT];
        low_clk_q <= wr_data[lpw_pkg::OSC_LOWCLK_BIT];
        stop_hosc_q <= wr_data[lpw_pkg::OSC_STOP_HOSC_BIT];
        xtal_q <= wr_data[lpw_pkg::OSC_XTAL_BIT];
      end
      if (state_q == lpw_pkg::ST_IDLE && wake_fire) begin
        idle_req_q <= 1'b0;
      end
      if (state_q == lpw_pkg::ST_SLEEP && wake_fire) begin
        sleep_req_q <= 1'b0;
      end
      if (warm_done) begin
        low_clk_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      p1_wake_en_q <= lpw_pkg::P1_WAKE_EN_RST;
    end else if (wr_en && wr_strb[0] && lpw_pkg::reg_hit(wr_addr, lpw_pkg::OFF_P1_WAKE_EN)) begin
      p1_wake_en_q <= wr_data[P1_W-1:0];
    end
  end

  // ==================================================================
  // Wake flag, global enable and interrupt requests.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_flag_q <= 1'b0;
    end else if (wake_fire && !wake_ext) begin
      wake_flag_q <= 1'b1;
    end else if (wctl_wr && wr_strb[0] && wr_data[lpw_pkg::WCTL_FLAG_BIT]) begin
      wake_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_ien_q <= 1'b0;
      int_edge_q <= lpw_pkg::INT_EDGE_RST;
    end else if (wctl_wr && wr_strb[0]) begin
      wake_ien_q <= wr_data[lpw_pkg::WCTL_IEN_BIT];
      int_edge_q <= wr_data[lpw_pkg::WCTL_EDGE_LSB +: 2];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gie_q <= 1'b0;
      in_svc_q <= 1'b0;
      vector_addr_q <= lpw_pkg::VECTOR_ADDR;
    end else if (take_svc) begin
      gie_q <= 1'b0;
      in_svc_q <= 1'b1;
      vector_addr_q <= lpw_pkg::VECTOR_ADDR;
    end else if (cpu_reti && in_svc_q) begin
      gie_q <= 1'b1;
      in_svc_q <= 1'b0;
    end else if (wctl_wr && wr_strb[0]) begin
      gie_q <= wr_data[lpw_pkg::WCTL_GIE_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_req_q <= lpw_pkg::IRQ_RST;
      int_en_q <= lpw_pkg::IRQ_RST;
    end else begin
      int_req_q <= (int_req_q & ~((int_wr && wr_strb[0]) ? wr_data[6:0] : 7'h00)) | irq_set;
      if (int_wr && wr_strb[1]) begin
        int_en_q <= wr_data[lpw_pkg::INT_EN_LSB +: lpw_pkg::NUM_IRQ];
      end
    end
  end

  // ==================================================================
  // Clock enables and outputs.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= 2'h0;
      clk_en_q <= 1'b0;
    end else begin
      if (losc_tick) begin
        div_q <= div_q + 2'h1;
      end
      clk_en_q <= (state_q == lpw_pkg::ST_RUN || state_q == lpw_pkg::ST_IDLE) && (!low_clk_q || slow_tick);
    end
  end

  assign cpu_halt = state_q != lpw_pkg::ST_RUN;
  assign sys_clk_en = clk_en_q;
  assign hosc_run = state_q == lpw_pkg::ST_WARM || (state_q != lpw_pkg::ST_SLEEP && !stop_hosc_q);
  assign losc_run = state_q != lpw_pkg::ST_SLEEP;
  assign basic_timer_run = state_q == lpw_pkg::ST_RUN || state_q == lpw_pkg::ST_IDLE;
  assign pwm_run = state_q == lpw_pkg::ST_RUN || state_q == lpw_pkg::ST_IDLE;
  assign mode_slow = low_clk_q;
  assign vector_req = take_svc;
  assign vector_addr = vector_addr_q;

  always_comb begin
    rd_data = '0;
    rd_hit = 1'b1;
    if (lpw_pkg::reg_hit(rd_addr, lpw_pkg::OFF_OSC_MODE)) begin
      rd_data[4:0] = {xtal_q, stop_hosc_q, low_clk_q, idle_req_q, sleep_req_q};
    end else if (lpw_pkg::reg_hit(rd_addr, lpw_pkg::OFF_WAKE_CTL)) begin
      rd_data[5:0] = {int_edge_q, in_svc_q, gie_q, wake_ien_q, wake_flag_q};
      rd_data[lpw_pkg::WCTL_STATE_LSB +: 2] = state_q;
    end else if (lpw_pkg::reg_hit(rd_addr, lpw_pkg::OFF_INT_REQ)) begin
      rd_data[14:0] = {int_en_q, 1'b0, int_req_q};
    end else if (!lpw_pkg::reg_hit(rd_addr, lpw_pkg::OFF_P1_WAKE_EN)) begin
      rd_hit = 1'b0;
    end
  end

  assign wr_hit = lpw_pkg::reg_hit(wr_addr, lpw_pkg::OFF_OSC_MODE) ||
    lpw_pkg::reg_hit(wr_addr, lpw_pkg::OFF_WAKE_CTL) || lpw_pkg::reg_hit(wr_addr, lpw_pkg::OFF_INT_REQ) ||
    lpw_pkg::reg_hit(wr_addr, lpw_pkg::OFF_P1_WAKE_EN);

  // ==================================================================
  // Checks.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_idle_entry: assert property (state_q == lpw_pkg::ST_RUN && idle_req_q && !sleep_req_q
    |=> cpu_halt && hosc_run == !stop_hosc_q) else $error("idle request did not halt the cpu");
  chk_idle_clear: assert property ($past(state_q) == lpw_pkg::ST_IDLE && state_q == lpw_pkg::ST_RUN
    |-> !idle_req_q) else $error("idle request bit not cleared on wake");
  chk_pwm_nowake: assert property (state_q == lpw_pkg::ST_IDLE && pwm_ovf && !basic_timer_ovf && !pin_wake
    && !pend_q |=> state_q == lpw_pkg::ST_IDLE && pwm_run) else $error("pwm overflow woke the system");
  chk_sleep_timer: assert property (state_q == lpw_pkg::ST_SLEEP && basic_timer_ovf && !pin_wake && !pend_q
    |=> state_q == lpw_pkg::ST_SLEEP) else $error("timer woke the system from sleep");
  chk_sleep_normal: assert property (state_q == lpw_pkg::ST_WARM ##1 state_q == lpw_pkg::ST_RUN |-> !mode_slow)
    else $error("sleep wake did not end in normal mode");
  chk_wake_flag: assert property (wake_fire && !wake_ext |=> wake_flag_q)
    else $error("wake flag not set");
  chk_ext_wake: assert property (wake_fire && ext_wake && !pend_q && !wake_flag_q
    |=> !wake_flag_q && int_req_q[0]) else $error("external wake set the wake flag");
  chk_warm_len: assert property ($past(state_q) == lpw_pkg::ST_WARM && state_q == lpw_pkg::ST_RUN
    |-> $past(warm_cnt_q) == warm_last) else $error("warm-up length wrong");
  chk_idle_fast: assert property (state_q == lpw_pkg::ST_IDLE && wake_fire |=> state_q == lpw_pkg::ST_RUN)
    else $error("idle wake delayed");
  chk_gie_entry: assert property (vector_req |=> !gie_q && in_svc_q && vector_addr == 8'h08)
    else $error("service entry did not drop global enable");

  cov_idle_wake: cover property (state_q == lpw_pkg::ST_IDLE ##1 state_q == lpw_pkg::ST_RUN);
  cov_sleep_wake: cover property (state_q == lpw_pkg::ST_WARM ##1 state_q == lpw_pkg::ST_RUN);
  cov_pend_wake: cover property (pend_q && wake_fire);

endmodule

// ==== core/lpw_pkg.sv ====
// ====================================================================
// Shared constants and types for the low-power wake sequencer.
package lpw_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ==================================================================
  // Register map.
  localparam logic [7:0] OFF_P1_WAKE_EN = 8'hC0;
  localparam logic [7:0] OFF_OSC_MODE = 8'hC4;
  localparam logic [7:0] OFF_WAKE_CTL = 8'hC8;
  localparam logic [7:0] OFF_INT_REQ = 8'hCC;

  // ==================================================================
  // Field positions and reset values.
  localparam int OSC_SLEEP_BIT = 0;
  localparam int OSC_IDLE_BIT = 1;
  localparam int OSC_LOWCLK_BIT = 2;
  localparam int OSC_STOP_HOSC_BIT = 3;
  localparam int OSC_XTAL_BIT = 4;
  localparam logic OSC_BIT_RST = 1'b0;
  localparam int WCTL_FLAG_BIT = 0;
  localparam int WCTL_IEN_BIT = 1;
  localparam int WCTL_GIE_BIT = 2;
  localparam int WCTL_SVC_BIT = 3;
  localparam int WCTL_EDGE_LSB = 4;
  localparam int WCTL_STATE_LSB = 8;
  localparam logic [1:0] INT_EDGE_RST = 2'h0;
  localparam int INT_EN_LSB = 8;
  localparam int NUM_IRQ = 7;
  localparam int IRQ_EXT = 0;
  localparam logic [6:0] P1_WAKE_EN_RST = 7'h00;
  localparam logic [6:0] IRQ_RST = 7'h00;

  // ==================================================================
  // Timing counts.
  localparam int WARM_W = 12;
  localparam logic [11:0] WARM_XTAL_CLKS = 12'h800;
  localparam logic [11:0] WARM_RC_CLKS = 12'h020;
  localparam logic [1:0] SLOW_DIV_LAST = 2'h3;
  localparam logic [7:0] VECTOR_ADDR = 8'h08;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==================================================================
  // Types.
  typedef enum logic [1:0] {ST_RUN, ST_IDLE, ST_SLEEP, ST_WARM} lpw_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic awvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [ADDR_W-1:0] araddr;
    logic arvalid;
    logic rready;
  } lpw_axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } lpw_axil_rsp_t;

  // ==================================================================
  // Functions.
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] off);
    return addr[7:2] == off[7:2];
  endfunction

  function automatic logic edge_hit(input logic [1:0] sel, input logic rise, input logic fall);
    return (sel[0] & rise) | (sel[1] & fall);
  endfunction

endpackage

// ==== core/lpw_wake_edge.sv ====
`timescale 1ns/1ns
// ====================================================================
// Pin synchronisers and level-change detectors.
module lpw_wake_edge #(
  parameter int N = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [N-1:0] pin,
  output logic [N-1:0] rise,
  output logic [N-1:0] fall
);

  logic [N-1:0] meta_q;
  logic [N-1:0] sync_q;
  logic [N-1:0] prev_q;
  logic [2:0] armed_q;

  // Edges are masked until the pipeline holds real pin samples.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed_q <= 3'h0;
    end else begin
      armed_q <= {armed_q[1:0], 1'b1};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  for (genvar i = 0; i < N; i++) begin : g_pin
    assign rise[i] = armed_q[2] & sync_q[i] & ~prev_q[i];
    assign fall[i] = armed_q[2] & ~sync_q[i] & prev_q[i];
  end

endmodule

// ==== core/lpw_axil.sv ====
`timescale 1ns/1ns
// ====================================================================
// AXI4-Lite register slave, one write and one read in flight.
module lpw_axil (
  input wire logic aclk,
  input wire logic aresetn,
  input wire lpw_pkg::lpw_axil_req_t req,
  output lpw_pkg::lpw_axil_rsp_t rsp,
  output logic wr_en,
  output logic [lpw_pkg::ADDR_W-1:0] wr_addr,
  output logic [lpw_pkg::DATA_W-1:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_hit,
  output logic [lpw_pkg::ADDR_W-1:0] rd_addr,
  input wire logic [lpw_pkg::DATA_W-1:0] rd_data,
  input wire logic rd_hit
);

  logic aw_full_q;
  logic w_full_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [lpw_pkg::DATA_W-1:0] rdata_q;
  logic aw_take;
  logic w_take;

  assign aw_take = req.awvalid && !aw_full_q && !bvalid_q;
  assign w_take = req.wvalid && !w_full_q && !bvalid_q;
  assign wr_en = aw_full_q && w_full_q && !bvalid_q;
  assign rd_addr = req.araddr;

  always_comb begin
    rsp = '0;
    rsp.awready = !aw_full_q && !bvalid_q;
    rsp.wready = !w_full_q && !bvalid_q;
    rsp.bvalid = bvalid_q;
    rsp.bresp = bresp_q;
    rsp.arready = !rvalid_q;
    rsp.rvalid = rvalid_q;
    rsp.rdata = rdata_q;
    rsp.rresp = rresp_q;
  end

  // ==================================================================
  // Write channels.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= 4'h0;
    end else if (wr_en) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_full_q <= 1'b1;
        wr_addr <= req.awaddr;
      end
      if (w_take) begin
        w_full_q <= 1'b1;
        wr_data <= req.wdata;
        wr_strb <= req.wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= lpw_pkg::RESP_OKAY;
    end else if (wr_en) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? lpw_pkg::RESP_OKAY : lpw_pkg::RESP_SLVERR;
    end else if (req.bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ==================================================================
  // Read channels.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= lpw_pkg::RESP_OKAY;
    end else if (!rvalid_q && req.arvalid) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_hit ? rd_data : '0;
      rresp_q <= rd_hit ? lpw_pkg::RESP_OKAY : lpw_pkg::RESP_SLVERR;
    end else if (req.rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule

// ==== bench/lpw_partner.sv ====
`timescale 1ns/1ns
// ==================================================================
// Far-side model: oscillator ticks and the CPU's return from service.
module lpw_partner (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic vector_req,
  output logic hosc_tick,
  output logic losc_tick,
  output logic cpu_reti
);
  logic [4:0] svc_q;
  logic [1:0] div_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hosc_tick <= 1'b0;
      div_q <= 2'h0;
    end else begin
      hosc_tick <= ~hosc_tick;
      div_q <= div_q + 2'h1;
    end
  end
  assign losc_tick = (div_q == 2'h3);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      svc_q <= 5'h00;
    end else if (vector_req) begin
      svc_q <= 5'h14;
    end else if (svc_q != 5'h00) begin
      svc_q <= svc_q - 5'h01;
    end
  end
  assign cpu_reti = (svc_q == 5'h01);
endmodule

// ==== bench/low_power_mode_wakeup_bench.sv ====
`timescale 1ns/1ns
// ==================================================================
// Register-driven sequence tests of the idle and sleep sequencer.
module low_power_mode_wakeup_bench;
  logic aclk = 1'b0;
  logic aresetn, hosc_tick, losc_tick, bt, pwm, reti, vreq;
  logic cpu_halt, sys_clk_en, hosc_run, losc_run, bt_run, pwm_run, mode_slow;
  logic [7:0] p0, vaddr;
  logic [6:0] p1;
  logic [31:0] d;
  logic [1:0] r;
  logic [2:0] cmp;
  logic adc;
  lpw_pkg::lpw_axil_req_t rq;
  lpw_pkg::lpw_axil_rsp_t rs;
  int num_errors = 0;
  int compares = 0;
  int cnt;
  always #2 aclk = ~aclk;
  lpw_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axil_req(rq), .s_axil_rsp(rs), .p0_pin(p0), .p1_pin(p1),
    .hosc_tick(hosc_tick), .losc_tick(losc_tick), .basic_timer_ovf(bt), .pwm_ovf(pwm), .cmp_irq(cmp),
    .adc_irq(adc), .cpu_reti(reti), .cpu_halt(cpu_halt), .sys_clk_en(sys_clk_en), .hosc_run(hosc_run),
    .losc_run(losc_run), .basic_timer_run(bt_run), .pwm_run(pwm_run), .mode_slow(mode_slow),
    .vector_req(vreq), .vector_addr(vaddr));
  lpw_partner PTN (.aclk(aclk), .aresetn(aresetn), .vector_req(vreq), .hosc_tick(hosc_tick),
    .losc_tick(losc_tick), .cpu_reti(reti));
  // ================================================================
  // Bus cycles and comparison.
  task results();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    logic aw, w, ta, tw, b;
    @(posedge aclk);
    rq.awaddr <= a;
    rq.wdata <= v;
    rq.wstrb <= 4'hF;
    rq.awvalid <= 1'b1;
    rq.wvalid <= 1'b1;
    rq.bready <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge aclk);
      ta = aw & rs.awready;
      tw = w & rs.wready;
      b = rs.bvalid & ~aw & ~w;
      @(posedge aclk);
      if (ta) rq.awvalid <= 1'b0;
      if (tw) rq.wvalid <= 1'b0;
      aw = aw & ~ta;
      w = w & ~tw;
    end
    rq.bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] s);
    logic ok;
    @(posedge aclk);
    rq.araddr <= a;
    rq.arvalid <= 1'b1;
    rq.rready <= 1'b1;
    do begin
      @(negedge aclk);
      ok = rs.arready;
      @(posedge aclk);
    end while (!ok);
    rq.arvalid <= 1'b0;
    do begin
      @(negedge aclk);
      ok = rs.rvalid;
      v = rs.rdata;
      s = rs.rresp;
      @(posedge aclk);
    end while (!ok);
    rq.rready <= 1'b0;
  endtask
  task tick_bt();
    @(posedge aclk);
    bt <= 1'b1;
    @(posedge aclk);
    bt <= 1'b0;
    @(negedge aclk);
  endtask
  task wait_run();
    cnt = 0;
    while (cpu_halt !== 1'b0 && cnt < 100) begin
      @(negedge aclk);
      cnt++;
    end
  endtask
  // ================================================================
  // Test sequence.
  initial begin
    rq = '0;
    p0 = 8'h00;
    p1 = 7'h01;
    bt = 1'b0;
    pwm = 1'b0;
    cmp = 3'h0;
    adc = 1'b0;
    aresetn = 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    chk(vaddr, lpw_pkg::VECTOR_ADDR, "vector address");
    rd(lpw_pkg::OFF_P1_WAKE_EN, d, r);
    chk(d, 32'h0, "p1 wake enable reads zero");
    rd(8'h10, d, r);
    chk(r, lpw_pkg::RESP_SLVERR, "unmapped read");
    wr(lpw_pkg::OFF_OSC_MODE, 32'h2);
    repeat (2) @(negedge aclk);
    chk({cpu_halt, sys_clk_en, bt_run, pwm_run}, 4'hF, "idle entry");
    @(posedge aclk);
    pwm <= 1'b1;
    @(posedge aclk);
    pwm <= 1'b0;
    repeat (4) @(negedge aclk);
    chk(cpu_halt, 1'b1, "pwm overflow woke");
    tick_bt();
    chk(cpu_halt, 1'b0, "idle timer wake");
    rd(lpw_pkg::OFF_OSC_MODE, d, r);
    chk(d[1], 1'b0, "idle bit not cleared");
    rd(lpw_pkg::OFF_WAKE_CTL, d, r);
    chk(d[0], 1'b1, "wake flag");
    wr(lpw_pkg::OFF_WAKE_CTL, 32'h1);
    wr(lpw_pkg::OFF_OSC_MODE, 32'h1);
    repeat (2) @(negedge aclk);
    chk({hosc_run, losc_run, cpu_halt}, 3'h1, "sleep entry");
    tick_bt();
    @(posedge aclk);
    p1 <= 7'h03;
    repeat (8) @(negedge aclk);
    chk(cpu_halt, 1'b1, "sleep false wake");
    @(posedge aclk);
    p0 <= 8'h08;
    cnt = 0;
    for (int i = 0; i < 400 && cpu_halt !== 1'b0; i++) begin
      @(negedge aclk);
      if (cpu_halt === 1'b1 && hosc_run === 1'b1 && hosc_tick === 1'b1) cnt++;
    end
    chk(cnt, 32, "warm-up ticks");
    chk(mode_slow, 1'b0, "sleep wake mode");
    rd(lpw_pkg::OFF_OSC_MODE, d, r);
    chk(d[0], 1'b0, "sleep bit not cleared");
    wr(lpw_pkg::OFF_P1_WAKE_EN, 32'h1);
    wr(lpw_pkg::OFF_OSC_MODE, 32'h6);
    repeat (4) @(posedge aclk);
    p1 <= 7'h02;
    wait_run();
    chk({cpu_halt, mode_slow}, 2'h1, "slow idle pin wake");
    wr(lpw_pkg::OFF_OSC_MODE, 32'h0);
    wr(lpw_pkg::OFF_WAKE_CTL, 32'h7);
    wr(lpw_pkg::OFF_OSC_MODE, 32'h2);
    repeat (3) @(posedge aclk);
    tick_bt();
    for (int i = 0; i < 10 && vreq !== 1'b1; i++) @(negedge aclk);
    chk(vreq, 1'b1, "wake vector");
    rd(lpw_pkg::OFF_WAKE_CTL, d, r);
    chk(d & 32'hC, 32'h8, "service entry enable");
    wr(lpw_pkg::OFF_WAKE_CTL, 32'h3);
    repeat (30) @(posedge aclk);
    rd(lpw_pkg::OFF_WAKE_CTL, d, r);
    chk(d & 32'hC, 32'h4, "service exit enable");
    wr(lpw_pkg::OFF_INT_REQ, 32'h17F);
    wr(lpw_pkg::OFF_WAKE_CTL, 32'h16);
    wr(lpw_pkg::OFF_OSC_MODE, 32'h11);
    repeat (2) @(posedge aclk);
    p0 <= 8'h09;
    cnt = 0;
    for (int i = 0; i < 5000 && vreq !== 1'b1; i++) begin
      @(negedge aclk);
      if (cpu_halt === 1'b1 && hosc_run === 1'b1 && hosc_tick === 1'b1) cnt++;
    end
    chk(cnt, 2048, "crystal warm-up ticks");
    chk(vreq, 1'b1, "external wake vector");
    rd(lpw_pkg::OFF_WAKE_CTL, d, r);
    chk(d[0], 1'b0, "external wake set flag");
    @(posedge aclk);
    cmp <= 3'h7;
    adc <= 1'b1;
    @(posedge aclk);
    cmp <= 3'h0;
    adc <= 1'b0;
    rd(lpw_pkg::OFF_INT_REQ, d, r);
    chk(d & 32'h7F7F, 32'h14F, "request flags");
    results();
  end
  initial begin
    #80000;
    num_errors++;
    $display("mismatch %0t watchdog", $time);
    results();
  end
endmodule
